/* File: core/pcc_defs.svh */
/*
  register offsets, field positions, reset values and counts for the clock control block.
  assumes it is included by bare name from the package and design files.
*/
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PCC_ADDR_SYNTH_CTRL 32'hFFFFF82C
`define PCC_ADDR_LOCK_STATE 32'hFFFFF824
`define PCC_ADDR_LOCKUP_SEL 32'hFFFFF82E
`define PCC_ADDR_PROG_CLK 32'hFFFFF82F
// ----------------------------------------
// field positions
// ----------------------------------------
`define PCC_BIT_RUN 0
`define PCC_BIT_SEL 1
`define PCC_BIT_LOCK 0
`define PCC_BIT_PCL_EN 4
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PCC_RST_SYNTH_CTRL 8'h01
`define PCC_RST_LOCKUP_SEL 2'h3
`define PCC_RST_PROG_CLK 8'h00
`define PCC_MULT_SYNTH 3'h4
`define PCC_MULT_BYPASS 3'h1
`define PCC_LOCK_BASE_EXP 10
`define PCC_LOCK_CNT_W 16
`define PCC_DIV_CNT_W 4
`endif

/* File: core/pcc_pkg.sv */
/*
  state types of the clock control block.
  assumes pcc_defs.svh is on the include path.
*/
`include "pcc_defs.svh"
package pcc_pkg;
  // control and register state of the top
  typedef struct packed {
    logic run;           // multiplier run bit
    logic sel;           // multiplier select bit as stored
    logic [1:0] lk_sel;  // lockup wait selection
    logic pcl_en;        // pin clock output enable
    logic [1:0] pcl_div; // pin clock divider code
    logic lock;          // 1 while unlocked
    logic active;        // multiplier really running
    logic act_prev;      // active one cycle ago
    logic clk_sel;       // effective clock selection
    logic [2:0] mult;    // operating clock ratio
    logic [7:0] rdata;   // read data register
  } pcc_ctrl_st_t;
  // lockup timer state
  typedef struct packed {
    logic busy;
    logic [`PCC_LOCK_CNT_W-1:0] cnt;
    logic [1:0] sel;
    logic done;
  } pcc_lock_st_t;
  // pin clock generator state
  typedef struct packed {
    logic [`PCC_DIV_CNT_W-1:0] cnt;
    logic en;
    logic [1:0] div;
    logic pin;
  } pcc_pcl_st_t;
endpackage : pcc_pkg

/* File: core/pcc_links.sv */
/*
  carriers between the control module and its lockup timer and pin clock generator.
  assumes all three sit on one clock.
*/
interface pcc_lock_if;
  logic start;     // one-cycle restart of the wait
  logic [1:0] sel; // wait selection
  logic tick;      // one oscillator period elapsed
  logic done;      // one-cycle end of the wait
  modport ctrl (output start, sel, tick, input done);
  modport timer (input start, sel, tick, output done);
endinterface : pcc_lock_if

interface pcc_pcl_if;
  logic en;        // requested pin enable
  logic [1:0] div; // requested divider code
  logic pin;       // pin level, from a flip-flop
  modport ctrl (output en, div, input pin);
  modport gen (input en, div, output pin);
endinterface : pcc_pcl_if

/* File: core/pcc_lock_timer.sv */
/*
  lockup wait timer: counts oscillator ticks up to 2^(base+sel).
  assumes start and tick are synchronous one-cycle pulses.
*/
`include "pcc_defs.svh"
module pcc_lock_timer #(
  parameter int LOCK_BASE = `PCC_LOCK_BASE_EXP
) (
  input wire logic clock,
  input wire logic rst_n,
  pcc_lock_if.timer lk
);
  import pcc_pkg::*;
  localparam logic [`PCC_LOCK_CNT_W-1:0] ONE = 1;
  // an exponent outside this range would overflow the counter
  if (LOCK_BASE < 1 || LOCK_BASE + 3 >= `PCC_LOCK_CNT_W) begin : g_bad_base
    $error("lock base exponent out of range");
  end
  pcc_lock_st_t s_q, s_d;
  logic [`PCC_LOCK_CNT_W-1:0] last;
  // last count of the selected wait
  assign last = (ONE << (LOCK_BASE + int'(s_q.sel))) - ONE;
  // ----------------------------------------
  // counting
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (lk.start) begin
      // restart from zero, latching the selection R22
      s_d.busy = 1'b1;
      s_d.cnt = '0;
      s_d.sel = lk.sel;
    end else if (s_q.busy && lk.tick) begin
      if (s_q.cnt == last) begin
        s_d.busy = 1'b0; // R02
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + ONE;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign lk.done = s_q.done;
  property p_done_count;
    @(posedge clock) disable iff (!rst_n)
      s_q.done |-> $past(s_q.cnt) == last && $past(lk.tick);
  endproperty
  a_done_count: assert property (p_done_count) else $error("wait ended early"); // R02
  property p_restart;
    @(posedge clock) disable iff (!rst_n)
      lk.start |=> s_q.busy && s_q.cnt == '0 && !s_q.done;
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart"); // R22
endmodule : pcc_lock_timer

/* File: core/pcc_pin_clock.sv */
/*
  divided pin clock with glitch-free enable and divider changes.
  assumes the main clock drives clock.
*/
`include "pcc_defs.svh"
module pcc_pin_clock (
  input wire logic clock,
  input wire logic rst_n,
  pcc_pcl_if.gen pc
);
  import pcc_pkg::*;
  pcc_pcl_st_t s_q, s_d;
  logic [`PCC_DIV_CNT_W-1:0] nxt;
  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    nxt = s_q.cnt + 4'h1;
    s_d.cnt = nxt;
    // settings only change at the wrap, where every tap is about to go low,
    // so no shortened high or low phase reaches the pin R23
    if (s_q.cnt == 4'hF) begin
      s_d.en = pc.en;
      s_d.div = pc.div;
    end
    // tap n of the counter is the main clock over 2^(n+1) R07
    s_d.pin = s_d.en & nxt[s_d.div]; // R06
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign pc.pin = s_q.pin;
  property p_div2;
    @(posedge clock) disable iff (!rst_n)
      s_q.en && s_q.div == 2'h0 && $stable(s_q.en) && $stable(s_q.div)
        |-> s_q.pin != $past(s_q.pin);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two broken"); // R07
  property p_low_off;
    @(posedge clock) disable iff (!rst_n) !s_q.en |-> !s_q.pin;
  endproperty
  a_low_off: assert property (p_low_off) else $error("pin not held low"); // R06
endmodule : pcc_pin_clock

/* File: core/pcc_clock_ctrl.sv */
/*
  clock multiplier control: run and select bits, lock status, lockup wait
  selection, low-power halt and the programmable clock pin.
  assumes a synchronous byte register port, an oscillator tick pulse and
  low-power mode levels from the power controller, all on clock.
*/
// The address-and-strobe port was left to the implementer.
`include "pcc_defs.svh"
// Operation
// R01: lockup wait chosen by byte-only two-bit field
// R02: codes select 2^10 to 2^13 oscillator periods
// R03: lockup selection resets to longest wait
// R04: software picks a wait of enough microseconds
// R05: software leaves selection alone during wait
// R06: pin low when disabled, clock when enabled
// R07: divider codes give main clock /2../16
// R08: pin clock register resets zero, bit access
// R09: software sets port functions before enable
// R10: pin enable only while multiplier runs; the code does not gate pcl_en with run
// R11: after reset run is 1, select 0
// R12: software waits for lock before selecting
// R13: software bypasses, waits eight clocks, stops
// R14: deep idle or stop halts, exit restores
// R15: software sets settle time from bypass
// R16: software sets longer settle time from multiplier
// R17: light idle leaves multiplier running
// R18: unused multiplier must be stopped by software
// R19: run clear forces bypass; select needs lock
// R20: lock reads 1 until lockup timer overflows
// R21: operating clock four times or equal oscillator
// R22: lockup timer restarts on run rising
// R23: pin clock switches without short pulses
module pcc_clock_ctrl #(
  parameter int LOCK_BASE = `PCC_LOCK_BASE_EXP
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  input wire logic bus_bit,
  input wire logic [2:0] bus_bit_idx,
  output logic [7:0] bus_rdata,
  input wire logic osc_tick,
  input wire logic deep_idle_mode,
  input wire logic stop_mode,
  output logic synth_active,
  output logic synth_clock_select,
  output logic [2:0] op_clock_mult,
  output logic prog_clock_pin
);
  import pcc_pkg::*;

  // ----------------------------------------
  // reset image
  // ----------------------------------------
  // lock reads 1 from reset until the first wait after release ends
  // run set, bypass selected, unlocked, longest wait, pin disabled R03 R08 R11
  localparam pcc_ctrl_st_t RST_ST = '{
    run: 1'(`PCC_RST_SYNTH_CTRL >> `PCC_BIT_RUN),
    sel: 1'b0,
    lk_sel: `PCC_RST_LOCKUP_SEL,
    pcl_en: 1'b0,
    pcl_div: 2'h0,
    lock: 1'b1,
    active: 1'b0,
    act_prev: 1'b0,
    clk_sel: 1'b0,
    mult: `PCC_MULT_BYPASS,
    rdata: 8'h00
  };

  pcc_ctrl_st_t s_q, s_d; // all control state
  logic halt;             // low-power request that stops the multiplier
  logic [7:0] ctrl_img;   // run/select register as read
  logic [7:0] lock_img;   // lock status register as read
  logic [7:0] lsel_img;   // lockup selection register as read
  logic [7:0] pcl_img;    // pin clock register as read

  pcc_lock_if lk ();
  pcc_pcl_if pc ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // single-bit write lands on one bit, byte write replaces all
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wd,
    input logic bit_op,
    input logic [2:0] idx
  );
    logic [7:0] r;
    r = old;
    if (bit_op) begin
      r[idx] = wd[0];
    end else begin
      r = wd;
    end
    return r;
  endfunction : merge

  // read either the whole byte or one bit in bit 0
  function automatic logic [7:0] pick(
    input logic [7:0] img,
    input logic bit_op,
    input logic [2:0] idx
  );
    logic [7:0] r;
    r = img;
    if (bit_op) begin
      r = {7'h00, img[idx]};
    end
    return r;
  endfunction : pick

  // ----------------------------------------
  // register images
  // ----------------------------------------
  // unused bits read as zero
  always_comb begin
    ctrl_img = 8'h00;
    ctrl_img[`PCC_BIT_RUN] = s_q.run;
    ctrl_img[`PCC_BIT_SEL] = s_q.sel;
    lock_img = 8'h00;
    lock_img[`PCC_BIT_LOCK] = s_q.lock;
    lsel_img = {6'h00, s_q.lk_sel};
    pcl_img = 8'h00;
    pcl_img[`PCC_BIT_PCL_EN] = s_q.pcl_en;
    pcl_img[1:0] = s_q.pcl_div;
  end

  // light idle is deliberately absent: the multiplier keeps running there R17
  assign halt = deep_idle_mode | stop_mode;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] wb;
    wb = 8'h00;
    s_d = s_q;
    s_d.rdata = 8'h00; // read data stands one cycle only

    // register writes
    // the lock status address has no write branch, so it is read-only
    if (bus_we) begin
      if (bus_addr == `PCC_ADDR_SYNTH_CTRL) begin
        wb = merge(ctrl_img, bus_wdata, bus_bit, bus_bit_idx);
        s_d.run = wb[`PCC_BIT_RUN];
        // select can only be set once locked; while unlocked a 1 leaves the stored select bit as it was R19
        s_d.sel = wb[`PCC_BIT_SEL] & (s_q.sel | ~s_q.lock);
      end else if (bus_addr == `PCC_ADDR_PROG_CLK) begin
        wb = merge(pcl_img, bus_wdata, bus_bit, bus_bit_idx); // R08
        s_d.pcl_en = wb[`PCC_BIT_PCL_EN];
        s_d.pcl_div = wb[1:0];
      end else if (bus_addr == `PCC_ADDR_LOCKUP_SEL) begin
        // whole bytes only: bit writes leave the field as it is R01
        if (!bus_bit) begin
          s_d.lk_sel = bus_wdata[1:0];
        end
      end
    end

    // clearing run drops back to bypass R19
    if (!s_d.run) begin
      s_d.sel = 1'b0;
    end

    // register reads, unmapped addresses read zero
    if (bus_re) begin
      if (bus_addr == `PCC_ADDR_SYNTH_CTRL) begin
        s_d.rdata = pick(ctrl_img, bus_bit, bus_bit_idx);
      end else if (bus_addr == `PCC_ADDR_LOCK_STATE) begin
        s_d.rdata = pick(lock_img, bus_bit, bus_bit_idx);
      end else if (bus_addr == `PCC_ADDR_PROG_CLK) begin
        s_d.rdata = pick(pcl_img, bus_bit, bus_bit_idx);
      end else if (bus_addr == `PCC_ADDR_LOCKUP_SEL) begin
        // bit reads are not served by this register
        if (!bus_bit) begin
          s_d.rdata = lsel_img;
        end
      end
    end

    // halted in deep idle or stop; the run and select bits are kept so that
    // leaving the mode brings back the state held before entry R14
    s_d.active = s_d.run & ~halt;
    s_d.act_prev = s_q.active;

    // lock status
    if (!s_q.active) begin
      s_d.lock = 1'b1; // stopped or halted reads unlocked
    end else if (lk.start) begin
      s_d.lock = 1'b1; // R20
    end else if (lk.done) begin
      s_d.lock = 1'b0; // R20
    end

    // the multiplied clock is only used while running and locked, so an
    // exit from low power sits in bypass until the wait is over
    s_d.clk_sel = s_d.sel & s_d.active & ~s_d.lock;
    s_d.mult = s_d.clk_sel ? `PCC_MULT_SYNTH : `PCC_MULT_BYPASS; // R21
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // synchronous reset: the reset image loads on any rising clock edge with rst_n low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= RST_ST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // lockup timer hookup
  // ----------------------------------------
  // each rise of the running state restarts the wait, including the one
  // right after reset release and each exit from a halting mode;
  // the timer latches the selection at start, so a late write cannot
  // shorten a wait already under way
  assign lk.start = s_q.active & ~s_q.act_prev; // R22
  assign lk.sel = s_q.lk_sel;                   // R02
  assign lk.tick = osc_tick;

  pcc_lock_timer #(
    .LOCK_BASE(LOCK_BASE)
  ) u_lock (
    .clock(clock),
    .rst_n(rst_n),
    .lk(lk)
  );

  // ----------------------------------------
  // pin clock hookup
  // ----------------------------------------
  // the generator takes new settings only at its wrap, trading up to
  // sixteen cycles of latency for a clean pin waveform
  assign pc.en = s_q.pcl_en;
  assign pc.div = s_q.pcl_div;

  pcc_pin_clock u_pcl (
    .clock(clock),
    .rst_n(rst_n),
    .pc(pc)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a register output, so no decode glitch reaches a pin
  assign bus_rdata = s_q.rdata;
  assign synth_active = s_q.active;
  assign synth_clock_select = s_q.clk_sel;
  assign op_clock_mult = s_q.mult;
  assign prog_clock_pin = pc.pin;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // reset checks look at the first edge after release, when the state
  // register shows the reset image and the inputs are live again
  sequence s_reset_seen;
    $past(!rst_n) && rst_n;
  endsequence

  sequence s_run_rise;
    !s_q.active ##1 s_q.active;
  endsequence

  property p_reset_state;
    @(posedge clock) s_reset_seen |-> s_q.run && !s_q.sel && s_q.lock;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state"); // R11

  property p_reset_lsel;
    @(posedge clock) s_reset_seen |-> s_q.lk_sel == 2'h3 && !s_q.pcl_en;
  endproperty
  a_reset_lsel: assert property (p_reset_lsel) else $error("bad reset select"); // R03

  property p_sel_needs_lock;
    @(posedge clock) disable iff (!rst_n) $rose(s_q.sel) |-> $past(!s_q.lock);
  endproperty
  a_sel_needs_lock: assert property (p_sel_needs_lock) else $error("select while unlocked"); // R19

  property p_stop_bypass;
    @(posedge clock) disable iff (!rst_n) !s_q.run |-> !s_q.sel && !s_q.clk_sel;
  endproperty
  a_stop_bypass: assert property (p_stop_bypass) else $error("select kept when stopped"); // R19

  property p_rise_unlocks;
    @(posedge clock) disable iff (!rst_n) s_run_rise |=> s_q.lock;
  endproperty
  a_rise_unlocks: assert property (p_rise_unlocks) else $error("lock not set on start"); // R20

  property p_lock_clear;
    @(posedge clock) disable iff (!rst_n) $fell(s_q.lock) |-> $past(lk.done);
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without overflow"); // R20

  property p_halt;
    @(posedge clock) disable iff (!rst_n) halt |=> !s_q.active ##1 s_q.lock;
  endproperty
  a_halt: assert property (p_halt) else $error("multiplier not halted"); // R14

  property p_restore;
    @(posedge clock) disable iff (!rst_n)
      halt && !bus_we |=> s_q.run == $past(s_q.run) && s_q.sel == $past(s_q.sel);
  endproperty
  a_restore: assert property (p_restore) else $error("settings lost in low power"); // R14

  property p_mult;
    @(posedge clock) disable iff (!rst_n)
      s_q.mult == (s_q.clk_sel ? `PCC_MULT_SYNTH : `PCC_MULT_BYPASS);
  endproperty
  a_mult: assert property (p_mult) else $error("wrong clock ratio"); // R21

  property p_pin_off;
    @(posedge clock) disable iff (!rst_n)
      !s_q.pcl_en [*1] ##0 !pc.en |-> ##[1:17] !prog_clock_pin;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin not low after disable"); // R06

  property p_lsel_byte_only;
    @(posedge clock) disable iff (!rst_n)
      bus_we && bus_bit && bus_addr == `PCC_ADDR_LOCKUP_SEL |=> $stable(s_q.lk_sel);
  endproperty
  a_lsel_byte_only: assert property (p_lsel_byte_only) else $error("bit write changed select"); // R01

  // a select write while unlocked must leave bypass in place
  property p_sel_refused;
    @(posedge clock) disable iff (!rst_n)
      bus_we && bus_addr == `PCC_ADDR_SYNTH_CTRL && s_q.lock && !s_q.sel |=> !s_q.sel;
  endproperty
  a_sel_refused: assert property (p_sel_refused) else $error("select set unlocked"); // R19

  // only deep idle and stop halt the multiplier, so light idle keeps it up
  property p_keep_running;
    @(posedge clock) disable iff (!rst_n)
      s_q.run && !halt && !bus_we |=> s_q.active;
  endproperty
  a_keep_running: assert property (p_keep_running) else $error("run set but halted"); // R17
endmodule : pcc_clock_ctrl

/* File: testbench/pcc_clock_ctrl_bench.sv */
/*
  self-checking bench for the clock multiplier control block.
  assumes pcc_defs.svh on the include path and the design compiled before it.
*/
`include "pcc_defs.svh"
module pcc_clock_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pcc_pkg::*;
  // ----------------------------------------
  // signals and bookkeeping
  // ----------------------------------------
  localparam int LB = 2; // short lockup exponent base keeps waits at 4..32 ticks
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] bus_addr = 32'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic bus_bit = 1'b0;
  logic [2:0] bus_bit_idx = 3'h0;
  logic [7:0] bus_rdata;
  logic osc_tick = 1'b0;
  logic deep_idle_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic synth_active, synth_clock_select, prog_clock_pin;
  logic [2:0] op_clock_mult;
  logic rd_flag = 1'b0; // a read was taken at the previous edge
  logic [7:0] exp_v;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic [7:0] rnd = 8'h1D; // lfsr state, seed 29
  int fails = 0;
  int checks = 0;

  pcc_clock_ctrl #(.LOCK_BASE(LB)) dut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_bit(bus_bit),
    .bus_bit_idx(bus_bit_idx), .bus_rdata(bus_rdata), .osc_tick(osc_tick),
    .deep_idle_mode(deep_idle_mode), .stop_mode(stop_mode), .synth_active(synth_active),
    .synth_clock_select(synth_clock_select), .op_clock_mult(op_clock_mult),
    .prog_clock_pin(prog_clock_pin));

  // free-running main clock, 40 ns period
  always #20 clock = ~clock;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : compare

  // one write cycle; bit mode carries the value in bit 0
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b, input int i);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_bit <= b;
    bus_bit_idx <= 3'(i);
    bus_we <= 1'b1;
    @(posedge clock);
    bus_we <= 1'b0;
  endtask : wr

  // one read cycle; the monitor compares the data one cycle later
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic b, input int i);
    @(posedge clock);
    bus_addr <= a;
    bus_bit <= b;
    bus_bit_idx <= 3'(i);
    bus_re <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    bus_re <= 1'b0;
  endtask : rd

  // oscillator period pulses, one clock wide with a gap
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      osc_tick <= 1'b1;
      @(posedge clock);
      osc_tick <= 1'b0;
    end
  endtask : tick

  // every complete pin level run must last exactly half a divided period
  task automatic measure(input int code);
    int half;
    int run;
    int seen;
    logic last;
    half = 1 << code;
    run = 0;
    seen = 0;
    repeat (40) @(posedge clock);
    // the first run has an unknown start, so it only sets the reference level
    last = prog_clock_pin;
    repeat (96) begin
      @(posedge clock);
      if (prog_clock_pin === last) begin
        run++;
      end else begin
        if (seen > 0) compare(8'(run), 8'(half), "pin half period");
        seen++;
        run = 1;
        last = prog_clock_pin;
      end
    end
    compare(8'(seen >= 96 / half - 2), 8'h01, "pin edge count");
  endtask : measure

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // read-data monitor and watchdog
  // ----------------------------------------
  always @(posedge clock) begin
    if (rd_flag && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      compare(bus_rdata, exp_v, "read data");
    end
    rd_flag <= bus_re;
  end

  // the whole sequence needs about a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`PCC_ADDR_SYNTH_CTRL, 8'h01, 1'b0, 0);
    rd(`PCC_ADDR_LOCK_STATE, 8'h01, 1'b0, 0);
    rd(`PCC_ADDR_LOCKUP_SEL, 8'h03, 1'b0, 0);
    rd(`PCC_ADDR_PROG_CLK, 8'h00, 1'b0, 0);
    compare({5'h0, op_clock_mult}, 8'h01, "mult after reset");
    $display("test reset values done");
    // every lockup code: stop safely, restart and count ticks to lock
    for (int c = 0; c < 4; c++) begin
      wr(`PCC_ADDR_SYNTH_CTRL, 8'h01, 1'b0, 0);
      repeat (8) @(posedge clock);
      wr(`PCC_ADDR_SYNTH_CTRL, 8'h00, 1'b0, 0);
      wr(`PCC_ADDR_LOCKUP_SEL, 8'(c), 1'b0, 0);
      wr(`PCC_ADDR_SYNTH_CTRL, 8'h01, 1'b0, 0);
      repeat (4) @(posedge clock);
      tick((1 << (LB + c)) - 1);
      wr(`PCC_ADDR_SYNTH_CTRL, 8'h03, 1'b0, 0);
      rd(`PCC_ADDR_SYNTH_CTRL, 8'h01, 1'b0, 0);
      rd(`PCC_ADDR_LOCK_STATE, 8'h01, 1'b0, 0);
      tick(1);
      repeat (3) @(posedge clock);
      rd(`PCC_ADDR_LOCK_STATE, 8'h00, 1'b0, 0);
      wr(`PCC_ADDR_SYNTH_CTRL, 8'h03, 1'b0, 0);
      repeat (2) @(posedge clock);
      compare({7'h0, synth_clock_select}, 8'h01, "select in use");
      compare({5'h0, op_clock_mult}, 8'h04, "mult in synth mode");
    end
    // byte-only lockup register: bit accesses have no effect
    wr(`PCC_ADDR_LOCKUP_SEL, 8'h00, 1'b1, 0);
    rd(`PCC_ADDR_LOCKUP_SEL, 8'h03, 1'b0, 0);
    rd(`PCC_ADDR_LOCKUP_SEL, 8'h00, 1'b1, 1);
    $display("test lockup waits done");
    // pin clock: each divider, enable set by a single-bit write
    for (int c = 0; c < 4; c++) begin
      wr(`PCC_ADDR_PROG_CLK, 8'(c), 1'b0, 0);
      wr(`PCC_ADDR_PROG_CLK, 8'h01, 1'b1, `PCC_BIT_PCL_EN);
      rd(`PCC_ADDR_PROG_CLK, 8'h10 | 8'(c), 1'b0, 0);
      rd(`PCC_ADDR_PROG_CLK, 8'h01, 1'b1, `PCC_BIT_PCL_EN);
      measure(c);
    end
    wr(`PCC_ADDR_PROG_CLK, 8'h00, 1'b1, `PCC_BIT_PCL_EN);
    repeat (40) @(posedge clock);
    repeat (32) begin
      @(posedge clock);
      compare({7'h0, prog_clock_pin}, 8'h00, "pin held low");
    end
    $display("test pin clock done");
    // stop mode halts the multiplier, exit restarts the lockup wait
    stop_mode <= 1'b1;
    repeat (3) @(posedge clock);
    compare({7'h0, synth_active}, 8'h00, "halted in stop");
    compare({5'h0, op_clock_mult}, 8'h01, "bypass in stop");
    rd(`PCC_ADDR_LOCK_STATE, 8'h01, 1'b0, 0);
    rd(`PCC_ADDR_SYNTH_CTRL, 8'h03, 1'b0, 0);
    stop_mode <= 1'b0;
    repeat (4) @(posedge clock);
    tick(31);
    repeat (3) @(posedge clock);
    rd(`PCC_ADDR_LOCK_STATE, 8'h01, 1'b0, 0);
    tick(1);
    repeat (3) @(posedge clock);
    rd(`PCC_ADDR_LOCK_STATE, 8'h00, 1'b0, 0);
    compare({7'h0, synth_clock_select}, 8'h01, "select restored");
    deep_idle_mode <= 1'b1;
    repeat (3) @(posedge clock);
    compare({7'h0, synth_active}, 8'h00, "halted in deep idle");
    deep_idle_mode <= 1'b0;
    repeat (2) @(posedge clock);
    compare({7'h0, synth_active}, 8'h01, "running after deep idle");
    $display("test low power done");
    // clearing run while selected forces bypass
    wr(`PCC_ADDR_SYNTH_CTRL, 8'h00, 1'b0, 0);
    rd(`PCC_ADDR_SYNTH_CTRL, 8'h00, 1'b0, 0);
    compare({5'h0, op_clock_mult}, 8'h01, "bypass after stop");
    // read-only lock register and random unmapped places
    wr(`PCC_ADDR_LOCK_STATE, 8'h00, 1'b0, 0);
    rd(`PCC_ADDR_LOCK_STATE, 8'h01, 1'b0, 0);
    repeat (4) begin
      rnd = lfsr_next(rnd);
      if (rnd[7:4] == 4'h2) rnd = rnd ^ 8'h80; // steer clear of mapped offsets
      wr(32'hFFFFF800 + {24'h0, rnd}, lfsr_next(rnd), 1'b0, 0);
      rd(32'hFFFFF800 + {24'h0, rnd}, 8'h00, 1'b0, 0);
    end
    rd(`PCC_ADDR_PROG_CLK, 8'h03, 1'b0, 0);
    repeat (3) @(posedge clock);
    $display("test unmapped access done");
    conclude();
  end
endmodule : pcc_clock_ctrl_bench
